// *** scp_ctrl_port.sv ***
// Serial control port: 3-/4-wire word receiver, readback and register locking
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Wire select 1, separate select 0: 3-wire
// - Word is rnw, 7 address, 16 data
// - Sample data on each serial clock rise
// - Chip select rise latches last 24 bits
// - Host sends address, device returns read data
// - Logic one on shared line is released
// - Both selects 1: 4-wire, dedicated output
// - Idle dedicated output: low or undriven
// - 4-wire read ignores data after address
// - Watchdog and system registers locked by default
// - Charger registers share the same lock
// - Writes to locked registers allowed only while key holds 0013h
// - Address 00h reads fixed part code
// - Address 01h reads revision and config pins
module scp_ctrl_port import scp_pkg::*; #(
	// Identity values are arbitrary
	parameter logic [15:0] PART_ID = 16'h5a5a,
	parameter logic [3:0] FUNCTIONAL_REVISION = 4'h1,
	parameter logic [7:0] REVISION_NUMBER = 8'h01,
	parameter logic [7:0] ROM_MASK_ID = 8'h01
) (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic I_SERIAL_CLK,
	input wire logic I_CHIP_SELECT_N,
	input wire logic I_SHARED_SERIAL_DATA,
	input wire logic [1:0] I_CONFIG_PIN_STATE,
	output logic O_SHARED_SERIAL_DATA,
	output logic O_SHARED_SERIAL_DATA_OE_N,
	output logic O_DEDICATED_SERIAL_OUTPUT,
	output logic O_DEDICATED_SERIAL_OUTPUT_OE_N,
	output logic O_SOFT_RESET_TRIGGER
);
	logic [4:0] sync_raw;
	logic [4:0] sync_s;
	logic sclk_s;
	logic cs_n_s;
	logic shared_serial_data_s;
	logic [1:0] conf_s;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;

	assign sync_raw = {I_CONFIG_PIN_STATE, I_SHARED_SERIAL_DATA, I_CHIP_SELECT_N, I_SERIAL_CLK};
	assign sclk_s = sync_s[0];
	assign cs_n_s = sync_s[1];
	assign shared_serial_data_s = sync_s[2];
	assign conf_s = sync_s[4:3];

	scp_sync #(
		.WIDTH(5),
		.RESET_VAL(SYNC_RESET)
	) u_sync (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_async(sync_raw),
		.o_sync(sync_s)
	);

	scp_edge #(
		.RESET_VAL(1'b0)
	) u_sclk_edge (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_level(sclk_s),
		.o_rise(sclk_rise),
		.o_fall(sclk_fall)
	);

	scp_edge #(
		.RESET_VAL(1'b1)
	) u_cs_edge (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_level(cs_n_s),
		.o_rise(cs_rise),
		.o_fall()
	);

	// Register storage
	logic [DATA_BITS-1:0] prot_q [PROT_REGS];
	logic [DATA_BITS-1:0] key_q;
	logic soft_rst_q;

	// Serial engine state
	logic [WORD_BITS-1:0] shift_q;
	logic [4:0] cnt_q;
	logic rd_q;
	logic [DATA_BITS-1:0] tx_q;
	logic [DATA_BITS-1:0] vld_q;
	logic bit_q;
	logic drv_q;
	logic sd_oe_n_q;
	logic dedicated_serial_output_q;
	logic dedicated_serial_output_oe_n_q;

	// Mode decode
	logic wire_mode_select;
	logic separate_output_select;
	logic open_drain_select;
	logic mode3;
	logic mode4;
	assign wire_mode_select = prot_q[IDX_IFC_CTRL][IFC_WIRE_MODE_BIT];
	assign separate_output_select = prot_q[IDX_IFC_CTRL][IFC_SEP_OUT_BIT];
	assign open_drain_select = prot_q[IDX_IFC_CTRL][IFC_OPEN_DRAIN_BIT];
	assign mode3 = wire_mode_select & ~separate_output_select;
	assign mode4 = wire_mode_select & separate_output_select;

	// Receive path
	logic take;
	logic in_bit;
	logic addr_done;
	logic rd_start;
	logic [ADDR_BITS-1:0] rd_addr;
	assign take = sclk_rise & ~cs_n_s & wire_mode_select;
	// Data pin ignored in 4-wire read
	assign in_bit = (mode4 & rd_q) ? 1'b0 : shared_serial_data_s;
	assign addr_done = take & (cnt_q == ADDR_LAST_CNT);
	assign rd_start = addr_done & shift_q[ADDR_BITS-1];
	assign rd_addr = {shift_q[ADDR_BITS-2:0], in_bit};

	// Latched word and write decode
	scp_word_t word_w;
	scp_prot_sel_t wsel;
	scp_prot_sel_t rsel;
	logic latch;
	logic wr;
	logic unlocked;
	assign word_w = scp_word_t'(shift_q);
	// Complete word only on select rise
	assign latch = cs_rise & (cnt_q == WORD_FULL_CNT) & wire_mode_select;
	assign wr = latch & ~word_w.rnw;
	assign wsel = scp_prot_lookup(word_w.addr);
	assign rsel = scp_prot_lookup(rd_addr);
	assign unlocked = (key_q == UNLOCK_VALUE);

	// Read data selection
	logic [DATA_BITS-1:0] info_word;
	logic [DATA_BITS-1:0] rd_data;
	assign info_word = {FUNCTIONAL_REVISION, conf_s, 2'b00, REVISION_NUMBER};
	// Fixed part code at address 00h
	assign rd_data = (rd_addr == ADDR_PART_ID[6:0]) ? PART_ID :
		(rd_addr == ADDR_DEV_INFO[6:0]) ? info_word :
		(rd_addr == ADDR_MASK_REVISION[6:0]) ? {8'h00, ROM_MASK_ID} :
		(rd_addr == ADDR_UNLOCK_KEY[6:0]) ? key_q :
		rsel.hit ? prot_q[rsel.idx] : 16'h0000;

	// Shift register and bit count
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			shift_q <= '0;
			cnt_q <= 5'h00;
		end else if (cs_n_s) begin
			cnt_q <= 5'h00;
		end else if (take) begin
			shift_q <= {shift_q[WORD_BITS-2:0], in_bit};
			cnt_q <= (cnt_q == WORD_FULL_CNT) ? cnt_q : cnt_q + 5'h01;
		end
	end

	// Readback shifter; bits change on clock fall so the host samples on rise
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rd_q <= 1'b0;
			tx_q <= '0;
			vld_q <= '0;
			bit_q <= 1'b1;
			drv_q <= 1'b0;
		end else if (cs_n_s) begin
			rd_q <= 1'b0;
			bit_q <= 1'b1;
			drv_q <= 1'b0;
		end else if (rd_start) begin
			rd_q <= 1'b1;
			tx_q <= rd_data;
			vld_q <= '1;
		end else if (sclk_fall & rd_q) begin
			bit_q <= tx_q[DATA_BITS-1];
			drv_q <= vld_q[DATA_BITS-1];
			tx_q <= {tx_q[DATA_BITS-2:0], 1'b1};
			vld_q <= {vld_q[DATA_BITS-2:0], 1'b0};
		end
	end

	// Pin drive; a one is never driven onto the shared line
	logic sd_oe_n_d;
	logic dedicated_serial_output_d;
	logic dedicated_serial_output_oe_n_d;
	logic sending;
	assign sending = drv_q & ~cs_n_s;
	assign sd_oe_n_d = ~(mode3 & sending & ~bit_q);
	// CMOS idles low, open drain idles released
	assign dedicated_serial_output_d = ~open_drain_select & sending & bit_q;
	assign dedicated_serial_output_oe_n_d = ~mode4 | (open_drain_select & ~(sending & ~bit_q));

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sd_oe_n_q <= 1'b1;
			dedicated_serial_output_q <= 1'b0;
			dedicated_serial_output_oe_n_q <= 1'b1;
		end else begin
			sd_oe_n_q <= sd_oe_n_d;
			dedicated_serial_output_q <= dedicated_serial_output_d;
			dedicated_serial_output_oe_n_q <= dedicated_serial_output_oe_n_d;
		end
	end

	assign O_SHARED_SERIAL_DATA = 1'b0;
	assign O_SHARED_SERIAL_DATA_OE_N = sd_oe_n_q;
	assign O_DEDICATED_SERIAL_OUTPUT = dedicated_serial_output_q;
	assign O_DEDICATED_SERIAL_OUTPUT_OE_N = dedicated_serial_output_oe_n_q;
	assign O_SOFT_RESET_TRIGGER = soft_rst_q;

	// Register writes; the interface control word keeps the port alive after reset
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			for (int i = 0; i < PROT_REGS; i++) begin
				prot_q[i] <= (i == int'(IDX_IFC_CTRL)) ? IFC_CTRL_RESET : PROT_RESET;
			end
		end else if (wr & wsel.hit & unlocked) begin
			prot_q[wsel.idx] <= word_w.data;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			key_q <= UNLOCK_KEY_RESET;
			soft_rst_q <= 1'b0;
		end else begin
			if (wr & (word_w.addr == ADDR_UNLOCK_KEY[6:0])) begin
				key_q <= word_w.data;
			end
			soft_rst_q <= wr & (word_w.addr == ADDR_PART_ID[6:0]);
		end
	end

	// Checks
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_B);

	property p_shared_only_3wire;
		!O_SHARED_SERIAL_DATA_OE_N |-> $past(mode3) && $past(!cs_n_s);
	endproperty
	a_shared_only_3wire: assert property (p_shared_only_3wire) else $error("Shared line driven outside 3-wire");

	property p_dedicated_serial_output_only_4wire;
		!O_DEDICATED_SERIAL_OUTPUT_OE_N |-> $past(mode4);
	endproperty
	a_dedicated_serial_output_only_4wire: assert property (p_dedicated_serial_output_only_4wire) else $error("Dedicated output driven outside 4-wire");

	property p_bit_on_rise;
		(cnt_q != $past(cnt_q)) && (cnt_q != 5'h00) |-> $past(take);
	endproperty
	a_bit_on_rise: assert property (p_bit_on_rise) else $error("Bit taken without clock rise");

	property p_no_write_without_latch;
		(key_q != $past(key_q)) |-> $past(cs_rise) && $past(cnt_q == WORD_FULL_CNT);
	endproperty
	a_no_write_without_latch: assert property (p_no_write_without_latch) else $error("Key changed without full word");

	property p_locked_hold;
		wr && wsel.hit && !unlocked |=> prot_q[$past(wsel.idx)] == $past(prot_q[wsel.idx]);
	endproperty
	a_locked_hold: assert property (p_locked_hold) else $error("Locked register was written");

	property p_unlocked_write;
		wr && wsel.hit && unlocked |=> prot_q[$past(wsel.idx)] == $past(word_w.data);
	endproperty
	a_unlocked_write: assert property (p_unlocked_write) else $error("Unlocked write lost");

	property p_part_id;
		rd_start && (rd_addr == ADDR_PART_ID[6:0]) |=> tx_q == PART_ID && rd_q;
	endproperty
	a_part_id: assert property (p_part_id) else $error("Part code not loaded");

	property p_info;
		rd_start && (rd_addr == ADDR_DEV_INFO[6:0]) |=>
			tx_q[CONFIG_PIN_LSB+1:CONFIG_PIN_LSB] == $past(conf_s) && tx_q[7:0] == REVISION_NUMBER;
	endproperty
	a_info: assert property (p_info) else $error("Device information wrong");

	property p_ignore_4wire;
		take && mode4 && rd_q |=> shift_q[0] == 1'b0;
	endproperty
	a_ignore_4wire: assert property (p_ignore_4wire) else $error("Data pin read in 4-wire read");

	property p_deselect_release;
		cs_n_s |=> ##1 O_SHARED_SERIAL_DATA_OE_N && !O_DEDICATED_SERIAL_OUTPUT;
	endproperty
	a_deselect_release: assert property (p_deselect_release) else $error("Line held while deselected");

	property p_cmos_idle;
		mode4 && !open_drain_select && !sending |=> !O_DEDICATED_SERIAL_OUTPUT && !O_DEDICATED_SERIAL_OUTPUT_OE_N;
	endproperty
	a_cmos_idle: assert property (p_cmos_idle) else $error("CMOS output not low when idle");

	property p_one_released;
		sending && bit_q |=> O_SHARED_SERIAL_DATA_OE_N;
	endproperty
	a_one_released: assert property (p_one_released) else $error("Logic one was driven");

	property p_readback_shift;
		sclk_fall && rd_q && !cs_n_s |=>
			bit_q == $past(tx_q[DATA_BITS-1]) && drv_q == $past(vld_q[DATA_BITS-1]);
	endproperty
	a_readback_shift: assert property (p_readback_shift) else $error("Read bit not shifted on fall");

	property p_key_write;
		wr && (word_w.addr == ADDR_UNLOCK_KEY[6:0]) |=> key_q == $past(word_w.data);
	endproperty
	a_key_write: assert property (p_key_write) else $error("Key write lost");

	property p_short_word_refused;
		cs_rise && (cnt_q != WORD_FULL_CNT) |=> key_q == $past(key_q) && !O_SOFT_RESET_TRIGGER;
	endproperty
	a_short_word_refused: assert property (p_short_word_refused) else $error("Short word used");

	property p_soft_reset_pulse;
		O_SOFT_RESET_TRIGGER |=> !O_SOFT_RESET_TRIGGER;
	endproperty
	a_soft_reset_pulse: assert property (p_soft_reset_pulse) else $error("Reset pulse too long");

	property p_charger_locked;
		wr && !unlocked && (word_w.addr == ADDR_CHG_CTRL2[6:0]) |=> prot_q[6] == $past(prot_q[6]);
	endproperty
	a_charger_locked: assert property (p_charger_locked) else $error("Charger slot written");
endmodule
`default_nettype wire

// *** scp_edge.sv ***
// Edge detector on a synchronised level
`timescale 1ns/1ps
`default_nettype none
module scp_edge #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_level,
	output logic o_rise,
	output logic o_fall
);
	logic prev_q;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_q <= RESET_VAL;
		end else begin
			prev_q <= i_level;
		end
	end

	assign o_rise = i_level & ~prev_q;
	assign o_fall = ~i_level & prev_q;
endmodule
`default_nettype wire

// *** scp_host.sv ***
// Host master model that drives the serial control port
`timescale 1ns/1ps
`default_nettype none
module scp_host import scp_pkg::*; (
	input wire logic i_clk,
	input wire logic i_sh,
	input wire logic i_ded,
	input wire logic i_four,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_sd,
	output logic o_sd_oe,
	output logic o_done,
	output logic [DATA_BITS-1:0] o_rd
);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_sd = 1'b0;
		o_sd_oe = 1'b0;
		o_done = 1'b0;
		o_rd = '0;
	end

	// one word, most significant bit first; n above 24 adds leading zeros
	// A leading zero keeps the first eight bits a write, since readback is chosen there
	task automatic xfer(input logic [WORD_BITS-1:0] w, input int n);
		int off;
		int j;
		logic [DATA_BITS-1:0] rd;
		off = (n > WORD_BITS) ? n - WORD_BITS : 0;
		rd = '0;
		@(posedge i_clk) o_cs_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		for (int k = 0; k <= n; k++) begin
			j = k - off;
			@(posedge i_clk);
			// sample just before the fall, since a bit stands until then
			if (w[WORD_BITS-1] && j > ADDR_BITS + 1) begin
				rd = {rd[DATA_BITS-2:0], i_four ? i_ded : i_sh};
			end
			o_sclk <= 1'b0;
			if (k == n) begin
				o_sd_oe <= 1'b0;
			// drive address and all write bits
			end else if (j <= ADDR_BITS || !w[WORD_BITS-1]) begin
				o_sd_oe <= 1'b1;
				o_sd <= (j < 0) ? 1'b0 : w[WORD_BITS-1-j];
			end else begin
				// jam the shared line in 4-wire reads
				o_sd_oe <= i_four;
				o_sd <= k[0];
			end
			if (k < n) begin
				repeat (3) @(posedge i_clk);
				@(posedge i_clk) o_sclk <= 1'b1;
				repeat (3) @(posedge i_clk);
			end
		end
		repeat (4) @(posedge i_clk);
		@(posedge i_clk) o_cs_n <= 1'b1;
		o_rd <= rd;
		o_done <= w[WORD_BITS-1] && n == WORD_BITS;
		@(posedge i_clk) o_done <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask

	task automatic spin(input int c);
		repeat (c) begin
			@(posedge i_clk) o_sclk <= 1'b1;
			repeat (3) @(posedge i_clk);
			@(posedge i_clk) o_sclk <= 1'b0;
			repeat (3) @(posedge i_clk);
		end
	endtask
endmodule
`default_nettype wire

// *** scp_pkg.sv ***
// Shared constants, types and address decode for the serial control port
package scp_pkg;
	localparam int WORD_BITS = 24;
	localparam int ADDR_BITS = 7;
	localparam int DATA_BITS = 16;
	localparam int PROT_REGS = 7;
	localparam logic [4:0] ADDR_LAST_CNT = 5'h07;
	localparam logic [4:0] WORD_FULL_CNT = 5'h18;
	// Register addresses as printed; the word carries only the low seven bits
	localparam logic [7:0] ADDR_PART_ID = 8'h00;
	localparam logic [7:0] ADDR_DEV_INFO = 8'h01;
	localparam logic [7:0] ADDR_MASK_REVISION = 8'h02;
	localparam logic [7:0] ADDR_WDOG_CTRL = 8'h03;
	localparam logic [7:0] ADDR_SYS_CTRL = 8'h04;
	localparam logic [7:0] ADDR_IFC_CTRL = 8'h06;
	localparam logic [7:0] ADDR_PWR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_CHG_CTRL0 = 8'ha8;
	localparam logic [7:0] ADDR_CHG_CTRL1 = 8'ha9;
	localparam logic [7:0] ADDR_CHG_CTRL2 = 8'haa;
	localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hdb;
	localparam logic [2:0] IDX_IFC_CTRL = 3'h2;
	localparam logic [15:0] UNLOCK_VALUE = 16'h0013;
	localparam logic [15:0] UNLOCK_KEY_RESET = 16'h0000;
	localparam logic [15:0] PROT_RESET = 16'h0000;
	localparam logic [15:0] IFC_CTRL_RESET = 16'h0002;
	localparam int IFC_WIRE_MODE_BIT = 1;
	localparam int IFC_SEP_OUT_BIT = 2;
	localparam int IFC_OPEN_DRAIN_BIT = 3;
	localparam int FUNC_REV_LSB = 12;
	localparam int CONFIG_PIN_LSB = 10;
	localparam logic [4:0] SYNC_RESET = 5'h02;

	typedef struct packed {
		logic rnw;
		logic [ADDR_BITS-1:0] addr;
		logic [DATA_BITS-1:0] data;
	} scp_word_t;

	typedef struct packed {
		logic hit;
		logic [2:0] idx;
	} scp_prot_sel_t;

	// Maps a word address onto the write-locked storage slots
	function automatic scp_prot_sel_t scp_prot_lookup(input logic [ADDR_BITS-1:0] addr);
		scp_prot_sel_t sel;
		sel = '{hit: 1'b1, idx: 3'h0};
		case (addr)
			ADDR_WDOG_CTRL[6:0]: sel.idx = 3'h0;
			ADDR_SYS_CTRL[6:0]: sel.idx = 3'h1;
			ADDR_IFC_CTRL[6:0]: sel.idx = IDX_IFC_CTRL;
			ADDR_PWR_CTRL[6:0]: sel.idx = 3'h3;
			ADDR_CHG_CTRL0[6:0]: sel.idx = 3'h4;
			ADDR_CHG_CTRL1[6:0]: sel.idx = 3'h5;
			ADDR_CHG_CTRL2[6:0]: sel.idx = 3'h6;
			default: sel.hit = 1'b0;
		endcase
		return sel;
	endfunction
endpackage

// *** scp_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module scp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds the second stage only
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the serial control port
`timescale 1ns/1ps
`default_nettype none
module tb_top import scp_pkg::*;;
	// Identity values are arbitrary
	localparam logic [15:0] PID = 16'h3c96;
	localparam logic [3:0] FREV = 4'h9;
	localparam logic [7:0] RNUM = 8'h5e;
	localparam logic [7:0] MID = 8'ha7;
	logic I_CLK;
	logic I_RST_B;
	logic [1:0] cfg;
	logic sclk, cs_n, hsd, hoe, done, sh_o, sh_oe_n, ded, ded_oe_n, srst, four, od;
	logic [15:0] rdat;
	logic [15:0] expq[$];
	logic [15:0] prot[7];
	logic [7:0] pa[7] = '{8'h03, 8'h04, 8'h06, 8'h0c, 8'ha8, 8'ha9, 8'haa};
	int err_total = 0;
	int compares = 0;
	int seed = 32'h1868;
	int pulses = 0;
	int p0;
	int hi = 0;
	// pull-ups, so a released line reads one
	wire logic sh = !((hoe && !hsd) || (!sh_oe_n && !sh_o));
	wire logic dw = ded_oe_n ? 1'b1 : ded;

	scp_ctrl_port #(.PART_ID(PID), .FUNCTIONAL_REVISION(FREV), .REVISION_NUMBER(RNUM),
		.ROM_MASK_ID(MID)) i_dut (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_SERIAL_CLK(sclk),
		.I_CHIP_SELECT_N(cs_n), .I_SHARED_SERIAL_DATA(sh), .I_CONFIG_PIN_STATE(cfg),
		.O_SHARED_SERIAL_DATA(sh_o), .O_SHARED_SERIAL_DATA_OE_N(sh_oe_n),
		.O_DEDICATED_SERIAL_OUTPUT(ded), .O_DEDICATED_SERIAL_OUTPUT_OE_N(ded_oe_n),
		.O_SOFT_RESET_TRIGGER(srst));
	scp_host i_host (.i_clk(I_CLK), .i_sh(sh), .i_ded(dw), .i_four(four), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_sd(hsd), .o_sd_oe(hoe), .o_done(done), .o_rd(rdat));

	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic results();
		$display("Compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		i_host.xfer({1'b0, a, d}, WORD_BITS);
	endtask

	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		expq.push_back(e);
		i_host.xfer({1'b1, a, e}, WORD_BITS);
	endtask

	always @(posedge I_CLK) begin
		if (done === 1'b1) begin
			chk(expq.size() > 0 ? expq.pop_front() : 16'hdead, rdat);
		end
		if (srst === 1'b1) pulses++;
		hi = cs_n ? hi + 1 : 0;
		if (hi > 8) chk(16'h0001, 16'(sh_oe_n));
		if (!sh_oe_n) chk(16'h0000, 16'(sh_o));
		if (hoe && !cs_n) chk(16'h0001, 16'(sh_oe_n));
		if (four && hi > 12) chk(16'(od), 16'(dw));
	end

	initial begin
		I_CLK = 1'b0;
		forever #2 I_CLK = ~I_CLK;
	end

	initial begin
		repeat (100000) @(posedge I_CLK);
		err_total++;
		results();
	end

	initial begin
		I_RST_B = 1'b0;
		four = 1'b0;
		od = 1'b0;
		cfg = 2'($random(seed));
		repeat (12) @(posedge I_CLK);
		I_RST_B <= 1'b1;
		repeat (4) @(posedge I_CLK);
		rd(7'h00, PID);
		rd(7'h01, {FREV, cfg, 2'b00, RNUM});
		rd(7'h02, {8'h00, MID});
		rd(7'h5b, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			prot[i] = 16'($random(seed));
			prot[i][3:0] = 4'h2;
			wr(pa[i][6:0], prot[i]);
			rd(pa[i][6:0], i == 2 ? 16'h0002 : 16'h0000);
		end
		// Key one below the unlock value keeps the lock
		wr(7'h5b, 16'h0012);
		wr(pa[1][6:0], prot[1]);
		rd(pa[1][6:0], 16'h0000);
		i_host.xfer({1'b0, 7'h5b, 16'h0013}, 23);
		rd(7'h5b, 16'h0012);
		i_host.xfer({1'b0, 7'h5b, 16'h0013}, 25);
		rd(7'h5b, 16'h0013);
		for (int i = 0; i < 7; i++) wr(pa[i][6:0], prot[i]);
		i_host.spin(5);
		for (int i = 0; i < 7; i++) rd(pa[i][6:0], prot[i]);
		wr(7'h5b, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr(pa[i][6:0], prot[i] ^ 16'h5a50);
			rd(pa[i][6:0], prot[i]);
		end
		p0 = pulses;
		wr(7'h00, 16'h0000);
		chk(16'(p0 + 1), 16'(pulses));
		rd(7'h00, PID);
		wr(7'h5b, 16'h0013);
		wr(7'h06, 16'h0006);
		four = 1'b1;
		// Long idle so the dedicated output is checked in CMOS mode
		repeat (8) @(posedge I_CLK);
		rd(pa[3][6:0], prot[3]);
		rd(7'h01, {FREV, cfg, 2'b00, RNUM});
		wr(7'h06, 16'h000e);
		od = 1'b1;
		repeat (8) @(posedge I_CLK);
		rd(pa[5][6:0], prot[5]);
		wr(7'h06, 16'h0002);
		four = 1'b0;
		od = 1'b0;
		rd(7'h06, 16'h0002);
		wr(7'h5b, 16'h0000);
		repeat (20) @(posedge I_CLK);
		chk(16'h0000, 16'(expq.size()));
		results();
	end
endmodule
`default_nettype wire
